// ---- common/csc_regs.svh ----
// register offsets, field positions, reset values and timing counts of the clock source switch
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// register byte offsets
`define CSC_OSC_CTRL_OFS 8'h00
`define CSC_CONFIG_OFS 8'h04

// oscillator_control_reg fields
`define CSC_SEL_BIT 0
`define CSC_TMO_BIT 3
`define CSC_IFREQ_LSB 4
`define CSC_IFREQ_MSB 6

// config_word_one fields
`define CSC_FOSC_LSB 0
`define CSC_FOSC_MSB 2
`define CSC_TWOSPD_BIT 3

// reset values
`define CSC_IFREQ_RST 3'h6
`define CSC_FOSC_RST 3'h1
`define CSC_TWOSPD_RST 1'h1

// oscillator mode codes of the crystal modes
`define CSC_FOSC_LOWPWR 3'h0
`define CSC_FOSC_XTAL 3'h1
`define CSC_FOSC_HISPD 3'h2

// oscillator cycles counted by the start-up timer
`define CSC_STARTUP_CYCLES 1024

`endif

// ---- common/csc_pkg.sv ----
// types shared by the clock source switch
package csc_pkg;

   // start-up sequencer states, one-hot
   typedef enum logic [3:0]
   {
      CSC_ST_POR = 4'h1,
      CSC_ST_COUNT = 4'h2,
      CSC_ST_RUN = 4'h4,
      CSC_ST_SLEEP = 4'h8
   } csc_state_e;

   // avalon-mm request from the bus master
   typedef struct packed
   {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } csc_avm_req_s;

endpackage

// ---- hw/csc_top.sv ----
// clock source selection with two-speed start-up and glitch-free switchover
`timescale 1ns/10ps
`include "csc_regs.svh"
// How it works
// - select bit 0: configured oscillator mode drives clock
// - select bit 1: internal oscillator at chosen frequency
// - every reset clears the select bit
// - automatic switches never touch the select bit
// - timeout status shows external source is ready, set even while select 1 runs internal
// - sleep aborts start-up, timeout status stays clear
// - crystal modes, select 0, two-speed off: timer holds execution 1024 cycles
// - two-speed: run internal, switch after 1024 counts
// - two-speed needs enable, select 0, crystal mode
// - two-speed entered after power-up and each wake
// - non-crystal modes skip start-up entirely
module csc_top #(
   parameter int STARTUP_CYCLES = `CSC_STARTUP_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire csc_pkg::csc_avm_req_s avm_req,
   output logic [31:0] avm_readdata,
   output logic avm_waitrequest,
   input wire logic ext_osc_tick,
   input wire logic int_osc_tick,
   input wire logic power_up_timer_done,
   input wire logic sleep_req,
   input wire logic wake_evt,
   output logic sys_clk_en,
   output logic cpu_run,
   output logic clk_src_internal
);
   import csc_pkg::*;

   localparam int OW = $clog2(STARTUP_CYCLES + 1);
   localparam logic [OW-1:0] SUT_LAST = OW'(STARTUP_CYCLES - 1);

   // elaboration check on the start-up count
   if (STARTUP_CYCLES < 2)
   begin : g_bad_count
      $error("STARTUP_CYCLES must be at least 2");
   end

   logic sel_q;
   logic [2:0] ifreq_q;
   logic [2:0] fosc_q;
   logic twospd_en_q;
   logic tmo_stat_q;
   logic ack_q;
   logic [31:0] rdata_q;
   csc_state_e state_q;
   logic [OW-1:0] sut_cnt_q;
   logic [6:0] div_q;
   logic cur_int_q;
   logic sw_q;
   logic crystal;
   logic two_speed;
   logic want_int;
   logic int_div_tick;
   logic cur_tick;
   logic new_tick;
   logic sut_done;
   logic hit_osc;
   logic hit_cfg;
   logic wr_osc;
   logic wr_cfg;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////
   // register bus

   // one wait state per access
   assign avm_waitrequest = (avm_req.read | avm_req.write) & ~ack_q;
   assign avm_readdata = rdata_q;
   assign hit_osc = avm_req.address == `CSC_OSC_CTRL_OFS;
   assign hit_cfg = avm_req.address == `CSC_CONFIG_OFS;
   assign wr_osc = avm_req.write & ack_q & hit_osc & avm_req.byteenable[0];
   assign wr_cfg = avm_req.write & ack_q & hit_cfg & avm_req.byteenable[0];

   // read mux, unmapped reads as zero
   always_comb
   begin
      rd_mux = 32'h0;
      if (hit_osc)
      begin
         rd_mux[`CSC_SEL_BIT] = sel_q;
         rd_mux[`CSC_TMO_BIT] = tmo_stat_q;
         rd_mux[`CSC_IFREQ_MSB:`CSC_IFREQ_LSB] = ifreq_q;
      end
      else if (hit_cfg)
      begin
         rd_mux[`CSC_FOSC_MSB:`CSC_FOSC_LSB] = fosc_q;
         rd_mux[`CSC_TWOSPD_BIT] = twospd_en_q;
      end
   end

   // acknowledge and read data capture
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
      end
      else
      begin
         ack_q <= (avm_req.read | avm_req.write) & ~ack_q;
         if (avm_req.read & ~ack_q)
         begin
            rdata_q <= rd_mux;
         end
      end
   end

   // oscillator control: only software writes move the select bit
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sel_q <= 1'b0;
         ifreq_q <= `CSC_IFREQ_RST;
      end
      else if (wr_osc)
      begin
         sel_q <= avm_req.writedata[`CSC_SEL_BIT];
         ifreq_q <= avm_req.writedata[`CSC_IFREQ_MSB:`CSC_IFREQ_LSB];
      end
   end

   // configuration word
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         fosc_q <= `CSC_FOSC_RST;
         twospd_en_q <= `CSC_TWOSPD_RST;
      end
      else if (wr_cfg)
      begin
         fosc_q <= avm_req.writedata[`CSC_FOSC_MSB:`CSC_FOSC_LSB];
         twospd_en_q <= avm_req.writedata[`CSC_TWOSPD_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start-up sequencer

   assign crystal = (fosc_q == `CSC_FOSC_LOWPWR) | (fosc_q == `CSC_FOSC_XTAL) | (fosc_q == `CSC_FOSC_HISPD);
   assign two_speed = twospd_en_q & ~sel_q & crystal;
   assign sut_done = (state_q == CSC_ST_COUNT) & ext_osc_tick & (sut_cnt_q == SUT_LAST) & ~sleep_req;

   // por wait, timer count, run and sleep
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_q <= CSC_ST_POR;
      end
      else
      begin
         case (state_q)
            CSC_ST_POR:
               if (power_up_timer_done)
               begin
                  state_q <= crystal ? CSC_ST_COUNT : CSC_ST_RUN;
               end
            CSC_ST_COUNT:
               if (sleep_req)
               begin
                  state_q <= CSC_ST_SLEEP;
               end
               else if (sut_done)
               begin
                  state_q <= CSC_ST_RUN;
               end
            CSC_ST_RUN:
               if (sleep_req)
               begin
                  state_q <= CSC_ST_SLEEP;
               end
            CSC_ST_SLEEP:
               if (wake_evt)
               begin
                  state_q <= crystal ? CSC_ST_COUNT : CSC_ST_RUN;
               end
            default:
               state_q <= CSC_ST_POR;
         endcase
      end
   end

   // start-up timer counts external oscillator cycles
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sut_cnt_q <= '0;
      end
      else if (state_q != CSC_ST_COUNT)
      begin
         sut_cnt_q <= '0;
      end
      else if (ext_osc_tick & ~sut_done)
      begin
         sut_cnt_q <= sut_cnt_q + OW'(1);
      end
   end

   // timeout status: set on timer expiry or a non-crystal run, whatever the select bit
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         tmo_stat_q <= 1'b0;
      end
      else if (sleep_req | (state_q == CSC_ST_SLEEP) | (state_q == CSC_ST_POR))
      begin
         tmo_stat_q <= 1'b0;
      end
      else if (sut_done | ((state_q == CSC_ST_RUN) & ~crystal))
      begin
         tmo_stat_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock selection

   // internal frequency divider, select code 7 is the full rate
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         div_q <= 7'h0;
      end
      else if (int_osc_tick)
      begin
         div_q <= div_q + 7'h1;
      end
   end

   assign int_div_tick = int_osc_tick & ((div_q & (7'h7f >> ifreq_q)) == 7'h0);
   // internal while select is set or two-speed counting
   assign want_int = sel_q | ((state_q == CSC_ST_COUNT) & two_speed);
   assign cur_tick = cur_int_q ? int_div_tick : ext_osc_tick;
   assign new_tick = cur_int_q ? ext_osc_tick : int_div_tick;

   // switch after an old-source edge, settle on a new-source edge
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cur_int_q <= 1'b0;
         sw_q <= 1'b0;
      end
      else if (sw_q & new_tick)
      begin
         cur_int_q <= ~cur_int_q;
         sw_q <= 1'b0;
      end
      else if (~sw_q & (want_int != cur_int_q) & cur_tick)
      begin
         sw_q <= 1'b1;
      end
   end

   // execution held while the timer counts with neither two-speed nor the select bit set
   assign cpu_run = (state_q == CSC_ST_RUN) | ((state_q == CSC_ST_COUNT) & (two_speed | sel_q));
   assign sys_clk_en = cpu_run & ~sw_q & cur_tick;
   assign clk_src_internal = cur_int_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence count_last_s;
      (state_q == CSC_ST_COUNT) && ext_osc_tick && (sut_cnt_q == SUT_LAST) && !sleep_req;
   endsequence

   sequence in_run_s;
      (state_q == CSC_ST_RUN) && tmo_stat_q;
   endsequence

   // suppressed new-source tick, then the source has changed
   sequence settle_s;
      !sys_clk_en ##1 (!sw_q && $changed(cur_int_q));
   endsequence

   select_reset_a: assert property (@(posedge mclk) $fell(reset) |-> !sel_q)
      else $error("select bit not clear after reset");
   select_sw_only_a: assert property (@(posedge mclk) disable iff (reset)
      $changed(sel_q) |-> $past(wr_osc))
      else $error("select bit changed without a write");
   count_done_a: assert property (@(posedge mclk) disable iff (reset) count_last_s |=> in_run_s)
      else $error("timer expiry did not set status and run");
   sleep_abort_a: assert property (@(posedge mclk) disable iff (reset)
      sleep_req |=> !tmo_stat_q && (state_q == CSC_ST_SLEEP))
      else $error("sleep did not abort start-up");
   exec_hold_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == CSC_ST_COUNT) && !two_speed && !sel_q |-> !cpu_run)
      else $error("execution not held during start-up");
   two_speed_int_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == CSC_ST_COUNT) && two_speed |-> want_int && cpu_run)
      else $error("two-speed not running internal");
   count_crystal_a: assert property (@(posedge mclk) disable iff (reset)
      $rose(state_q == CSC_ST_COUNT) |-> $past(crystal))
      else $error("start-up entered for non-crystal mode");
   // the last external tick before a switch is allowed, then the switch must start
   select_src_a: assert property (@(posedge mclk) disable iff (reset)
      sel_q && !sw_q && sys_clk_en |-> if (clk_src_internal) int_div_tick else ##1 sw_q)
      else $error("select bit set but clock not internal");
   clean_tick_a: assert property (@(posedge mclk) disable iff (reset)
      sys_clk_en |-> !sw_q && (cur_int_q ? int_div_tick : ext_osc_tick))
      else $error("system tick not from current source");
   switch_seq_a: assert property (@(posedge mclk) disable iff (reset)
      sw_q && new_tick |-> settle_s)
      else $error("tick leaked during switchover");

endmodule

// ---- tb/csc_osc_model.sv ----
// oscillator model: external crystal and internal oscillator ticks
`timescale 1ns/10ps
module csc_osc_model #(
   parameter int EXT_DIV = 3,
   parameter int INT_DIV = 2
) (
   input wire logic mclk,
   input wire logic reset,
   output logic ext_osc_tick,
   output logic int_osc_tick
);
   int ext_q;
   int int_q;
   ////////////////////////////////
   // free-running dividers, one pulse per oscillator cycle
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ext_q <= 0;
         int_q <= 0;
      end
      else
      begin
         ext_q <= (ext_q == EXT_DIV - 1) ? 0 : ext_q + 1;
         int_q <= (int_q == INT_DIV - 1) ? 0 : int_q + 1;
      end
   end
   // tick outputs
   assign ext_osc_tick = (ext_q == EXT_DIV - 1);
   assign int_osc_tick = (int_q == INT_DIV - 1);
endmodule

// ---- tb/csc_top_tb.sv ----
// self-checking bench of the clock source switch
`timescale 1ns/10ps
module csc_top_tb;
   import csc_pkg::*;
   logic mclk;
   logic reset;
   csc_avm_req_s req;
   logic [31:0] rdata;
   logic waitreq;
   logic ext_tick;
   logic int_tick;
   logic power_up_timer_done;
   logic sleep_req;
   logic wake_evt;
   logic sys_clk_en;
   logic cpu_run;
   logic src_int;
   logic [31:0] rd;
   int err_total;
   int samples_checked;
   int cnt;
   ////////////////////////////////
   // short start-up count keeps the run brief
   csc_top #(.STARTUP_CYCLES(16)) i_dut (.mclk(mclk), .reset(reset), .avm_req(req), .avm_readdata(rdata),
      .avm_waitrequest(waitreq), .ext_osc_tick(ext_tick), .int_osc_tick(int_tick),
      .power_up_timer_done(power_up_timer_done),
      .sleep_req(sleep_req), .wake_evt(wake_evt), .sys_clk_en(sys_clk_en), .cpu_run(cpu_run),
      .clk_src_internal(src_int));
   csc_osc_model i_osc (.mclk(mclk), .reset(reset), .ext_osc_tick(ext_tick), .int_osc_tick(int_tick));
   // clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   ////////////////////////////////
   task automatic finish_test();
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one access, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
      do
      begin
         @(posedge mclk);
      end while (waitreq !== 1'b0);
      rd = rdata;
      req <= '0;
   endtask
   // bounded wait for a level, counting cycles in cnt; sel 1 watches cpu_run, 0 the source flag
   task automatic wait_for(input bit sel, input logic v, input int lim);
      cnt = 0;
      while ((sel ? cpu_run : src_int) !== v && cnt < lim)
      begin
         @(posedge mclk);
         cnt++;
      end
      chk(32'(sel ? cpu_run : src_int), 32'(v));
   endtask
   task automatic pulse(input logic slp);
      @(posedge mclk);
      if (slp)
         sleep_req <= 1'b1;
      else
         wake_evt <= 1'b1;
      @(posedge mclk);
      sleep_req <= 1'b0;
      wake_evt <= 1'b0;
   endtask
   ////////////////////////////////
   task automatic t_reset();
      bus(1'h0, 8'h00, 32'h0);
      chk(rd, 32'h60);
      bus(1'h0, 8'h04, 32'h0);
      chk(rd, 32'h9);
      bus(1'h0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      chk(32'(cpu_run), 32'h0);
   endtask
   task automatic t_two_speed();
      power_up_timer_done <= 1'b1;
      wait_for(1'b0, 1'h1, 10);
      chk(32'(cpu_run), 32'h1);
      bus(1'h0, 8'h00, 32'h0);
      chk(rd, 32'h60);
      wait_for(1'b0, 1'h0, 200);
      bus(1'h0, 8'h00, 32'h0);
      chk(rd, 32'h68);
   endtask
   // internal source at two frequencies, then back
   task automatic t_select();
      for (int f = 7; f >= 5; f -= 2)
      begin
         bus(1'h1, 8'h00, 32'((f << 4) | 1));
         wait_for(1'b0, 1'h1, 20);
         repeat (8) @(posedge mclk);
         cnt = 0;
         repeat (160)
         begin
            @(negedge mclk);
            cnt += int'(sys_clk_en);
         end
         chk(32'(cnt >= (80 >> (7 - f)) - 1 && cnt <= (80 >> (7 - f)) + 1), 32'h1);
      end
      bus(1'h1, 8'h00, 32'h70);
      wait_for(1'b0, 1'h0, 20);
   endtask
   task automatic t_sleep();
      pulse(1'h1);
      repeat (4) @(posedge mclk);
      chk(32'(cpu_run), 32'h0);
      pulse(1'h0);
      wait_for(1'b0, 1'h1, 10);
      repeat (10) @(posedge mclk);
      pulse(1'h1);
      bus(1'h0, 8'h00, 32'h0);
      chk(rd & 32'h8, 32'h0);
      pulse(1'h0);
      wait_for(1'b0, 1'h1, 10);
      wait_for(1'b0, 1'h0, 200);
   endtask
   task automatic t_modes();
      bus(1'h1, 8'h04, 32'h1);
      pulse(1'h1);
      pulse(1'h0);
      wait_for(1'b1, 1'h1, 200);
      chk(32'(cnt >= 44 && cnt <= 54), 32'h1);
      chk(32'(src_int), 32'h0);
      bus(1'h1, 8'h04, 32'hc);
      pulse(1'h1);
      pulse(1'h0);
      repeat (4) @(posedge mclk);
      chk(32'(src_int), 32'h0);
      bus(1'h0, 8'h00, 32'h0);
      chk(rd & 32'h8, 32'h8);
   endtask
   ////////////////////////////////
   // main sequence
   initial
   begin
      reset = 1'b1;
      req = '0;
      power_up_timer_done = 1'b0;
      sleep_req = 1'b0;
      wake_evt = 1'b0;
      err_total = 0;
      samples_checked = 0;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_two_speed();
      t_select();
      t_sleep();
      t_modes();
      finish_test();
   end
   // watchdog, several times the expected run
   initial
   begin
      #100000;
      err_total++;
      finish_test();
   end
endmodule
